// ### design/dmach_pkg.sv
// Package for the DMA channel: register map, field layout, modes and states.
// Assumes a 32-bit Avalon-MM slave with word-aligned byte addresses.
package dmach_pkg;
	localparam int ADDR_W = 22;
	localparam int CNT_W = 12;
	localparam int BUS_AW = 6;
	localparam logic [BUS_AW-1:0] OFF_CTRL = 6'h00;
	localparam logic [BUS_AW-1:0] OFF_CFG = 6'h04;
	localparam logic [BUS_AW-1:0] OFF_SSA = 6'h08;
	localparam logic [BUS_AW-1:0] OFF_DSA = 6'h0C;
	localparam logic [BUS_AW-1:0] OFF_SSZ = 6'h10;
	localparam logic [BUS_AW-1:0] OFF_DSZ = 6'h14;
	localparam logic [BUS_AW-1:0] OFF_SPTR = 6'h18;
	localparam logic [BUS_AW-1:0] OFF_DPTR = 6'h1C;
	localparam logic [BUS_AW-1:0] OFF_SCNT = 6'h20;
	localparam logic [BUS_AW-1:0] OFF_DCNT = 6'h24;
	localparam logic [BUS_AW-1:0] OFF_BUF = 6'h28;
	localparam logic [BUS_AW-1:0] OFF_FLAG = 6'h2C;
	// Control register bits
	localparam int B_EN = 0;
	localparam int B_GO = 1;
	localparam int B_START_TRIGGER_ENABLE = 2;
	localparam int B_ABORT_TRIGGER_ENABLE = 3;
	localparam int B_PEND = 4;
	// Config register fields
	localparam int F_SOURCE_ADDRESS_MODE = 0;
	localparam int F_DESTINATION_ADDRESS_MODE = 2;
	localparam int F_SMR = 4;
	localparam int B_SOURCE_STOP = 6;
	localparam int B_DESTINATION_STOP = 7;
	// Flag register bits, write one to clear
	localparam int B_SFLAG = 0;
	localparam int B_DFLAG = 1;
	localparam logic [1:0] MODE_HOLD = 2'h0;
	localparam logic [1:0] MODE_INC = 2'h1;
	localparam logic [1:0] MODE_DEC = 2'h2;
	localparam logic [1:0] REGION_RAM = 2'h0;
	localparam logic [1:0] REGION_EEPROM = 2'h1;
	localparam logic [1:0] REGION_FLASH = 2'h2;
	localparam logic [31:0] RD_UNMAPPED = 32'h00000000;
	typedef enum logic [1:0] {
		DMACH_IDLE = 2'b00,
		DMACH_READ = 2'b01,
		DMACH_WRITE = 2'b11
	} dmach_state_t;
	typedef struct packed {
		logic req;
		logic [1:0] region;
		logic [ADDR_W-1:0] addr;
	} dmach_rd_req_t;
	typedef struct packed {
		logic req;
		logic [ADDR_W-1:0] addr;
		logic [7:0] data;
	} dmach_wr_req_t;
endpackage : dmach_pkg

// ### design/dmach_ptr.sv
// Pointer and counter pair for one side of the channel.
// Assumes step and load are one-cycle pulses on core_clk, never both at once.
`timescale 1ns/100ps
module dmach_ptr (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic load,
	input wire logic step,
	input wire logic [1:0] mode,
	input wire logic [dmach_pkg::ADDR_W-1:0] start_addr,
	input wire logic [dmach_pkg::CNT_W-1:0] size,
	output logic [dmach_pkg::ADDR_W-1:0] pointer,
	output logic [dmach_pkg::CNT_W-1:0] counter,
	output logic expire
);
	import dmach_pkg::*;
	logic [ADDR_W-1:0] ptr_nxt;
	logic [CNT_W-1:0] cnt_nxt;
	wire last_w = (counter == CNT_W'(1));
	assign expire = step && last_w;
	always_comb begin
		ptr_nxt = pointer;
		cnt_nxt = counter;
		if (load || expire) begin
			ptr_nxt = start_addr;
			cnt_nxt = size;
		end else if (step) begin
			cnt_nxt = counter - CNT_W'(1);
			unique case (mode)
				MODE_INC: ptr_nxt = pointer + ADDR_W'(1);
				MODE_DEC: ptr_nxt = pointer - ADDR_W'(1);
				default: ptr_nxt = pointer;
			endcase
		end
	end
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			pointer <= '0;
			counter <= '0;
		end else begin
			pointer <= ptr_nxt;
			counter <= cnt_nxt;
		end
	end
endmodule : dmach_ptr

// ### design/dmach_trig.sv
// Two-flop synchroniser with rising-edge detect for a trigger pin.
// Assumes the trigger is asynchronous to core_clk.
`timescale 1ns/100ps
module dmach_trig (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic trig_in,
	output logic level,
	output logic rise
);
	logic s1_r;
	logic s2_r;
	logic s3_r;
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
		end else begin
			s1_r <= trig_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end
	assign level = s2_r;
	assign rise = s2_r && !s3_r;
endmodule : dmach_trig

// ### design/dmach_top.sv
// DMA channel: pointers, counters, start and stop control, Avalon-MM register slave.
// Assumes a byte bus with rd_grant/wr_grant from the arbiter; read data valid with grant.
// How it works
// - First read and write addresses come from the two start address registers.
// - Source pointer holds, increments or decrements per mode after each transaction.
// - Destination pointer holds, increments or decrements per mode after each transaction.
// - Source region field selects flash, data EEPROM or register/RAM space.
// - Destination always writes register/RAM space; no region field.
// - Each transaction moves one byte; messages group transactions.
// - Setting enable copies sizes into counters; starting a transfer does not.
// - Both counters decrement by one after each transaction.
// - Message starts with transfer_go and ends when smaller counter expires.
// - Expired counter clears transfer_go and reloads its counter and pointer.
// - Counter decremented from one reloads at once, never reads zero.
// - Uneven sizes end last message early; remainder skews later messages.
// - Setting enable loads both pointers and counters.
// - Software start works only while enable is set.
// - Writing transfer_go while set has no effect.
// - transfer_go reads set when hardware start accepted and message runs.
// - Start trigger sampled only with its enable; clearing it spares current transaction.
// - Clearing transfer_go stops, keeps state; buffered byte is not written.
// - Abort trigger sampled only while its enable is set.
// - Abort clears transfer_go and both trigger enables, nothing else.
// - Stop option with counter reload stops further triggered messages.
// - Clearing enable stops, clears control bits and buffer; configuration, pointers and counters keep their values.
// - Stops take effect one cycle late; one more access may occur.
// - Transaction reads source into buffer, then writes buffer to destination.
// - write_pending set while buffer holds unwritten data.
// - Stop option ending a message clears start_trigger_enable.
// - Count flags set whenever a counter expires and reloads.
`timescale 1ns/100ps
module dmach_top (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic [dmach_pkg::BUS_AW-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic start_request,
	input wire logic abort_request,
	output dmach_pkg::dmach_rd_req_t rd_req,
	input wire logic rd_grant,
	input wire logic [7:0] rd_data,
	output dmach_pkg::dmach_wr_req_t wr_req,
	input wire logic wr_grant
);
	import dmach_pkg::*;
	logic enable_r;
	logic transfer_go_r;
	logic start_trigger_enable_r;
	logic abort_trigger_enable_r;
	logic [1:0] source_address_mode_r;
	logic [1:0] destination_address_mode_r;
	logic [1:0] source_memory_region_r;
	logic source_stop_r;
	logic destination_stop_r;
	logic [ADDR_W-1:0] source_start_address_r;
	logic [ADDR_W-1:0] destination_start_address_r;
	logic [CNT_W-1:0] source_size_r;
	logic [CNT_W-1:0] destination_size_r;
	logic [7:0] transfer_buffer_r;
	logic write_pending_r;
	logic source_count_flag_r;
	logic destination_count_flag_r;
	logic run_r;
	logic ack_r;
	logic waitreq_r;
	logic [31:0] rdata_r;
	dmach_state_t state_r;
	dmach_state_t state_nxt;
	dmach_rd_req_t rd_req_r;
	dmach_wr_req_t wr_req_r;
	logic [ADDR_W-1:0] source_pointer;
	logic [ADDR_W-1:0] destination_pointer;
	logic [CNT_W-1:0] source_counter;
	logic [CNT_W-1:0] destination_counter;
	logic src_expire;
	logic dst_expire;
	logic start_level;
	logic start_rise;
	logic abort_level;
	logic abort_rise;

	// Bus slave: one wait cycle, then acknowledge
	wire bus_req_w = (avs_read || avs_write) && !ack_r;
	wire wr_go_w = avs_write && ack_r;
	wire sel_ctrl_w = (avs_address == OFF_CTRL);
	wire sel_cfg_w = (avs_address == OFF_CFG);
	wire sel_flag_w = (avs_address == OFF_FLAG);
	wire wr_ctrl_w = wr_go_w && sel_ctrl_w;
	wire wr_cfg_w = wr_go_w && sel_cfg_w && !enable_r;
	wire wr_flag_w = wr_go_w && sel_flag_w;
	wire wr_ssa_w = wr_go_w && (avs_address == OFF_SSA);
	wire wr_dsa_w = wr_go_w && (avs_address == OFF_DSA);
	wire wr_ssz_w = wr_go_w && (avs_address == OFF_SSZ);
	wire wr_dsz_w = wr_go_w && (avs_address == OFF_DSZ);
	wire en_set_w = wr_ctrl_w && avs_writedata[B_EN] && !enable_r;
	wire en_clr_w = wr_ctrl_w && !avs_writedata[B_EN];
	wire sw_go_set_w = wr_ctrl_w && avs_writedata[B_GO] && enable_r && avs_writedata[B_EN];
	wire sw_go_clr_w = wr_ctrl_w && !avs_writedata[B_GO] && transfer_go_r;

	// Trigger pins through synchronisers
	dmach_trig u_start (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.trig_in(start_request),
		.level(start_level),
		.rise(start_rise)
	);
	dmach_trig u_abort (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.trig_in(abort_request),
		.level(abort_level),
		.rise(abort_rise)
	);
	wire hw_start_w = start_trigger_enable_r && start_level && enable_r && !transfer_go_r;
	wire abort_w = abort_trigger_enable_r && abort_rise && enable_r;
	wire stop_opt_w = (source_stop_r && src_expire) || (destination_stop_r && dst_expire);
	wire msg_end_w = src_expire || dst_expire;

	// Transaction engine
	wire read_done_w = (state_r == DMACH_READ) && rd_grant;
	wire write_done_w = (state_r == DMACH_WRITE) && wr_grant;
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			DMACH_IDLE: if (run_r && transfer_go_r) state_nxt = DMACH_READ;
			DMACH_READ: begin
				if (read_done_w) state_nxt = DMACH_WRITE;
				else if (!run_r) state_nxt = DMACH_IDLE;
			end
			DMACH_WRITE: begin
				if (write_done_w) state_nxt = DMACH_IDLE;
				else if (!run_r) state_nxt = DMACH_IDLE;
			end
			default: state_nxt = DMACH_IDLE;
		endcase
	end

	// Step pulses for both pointer pairs
	dmach_ptr u_src (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.load(en_set_w),
		.step(write_done_w),
		.mode(source_address_mode_r),
		.start_addr(source_start_address_r),
		.size(source_size_r),
		.pointer(source_pointer),
		.counter(source_counter),
		.expire(src_expire)
	);
	dmach_ptr u_dst (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.load(en_set_w),
		.step(write_done_w),
		.mode(destination_address_mode_r),
		.start_addr(destination_start_address_r),
		.size(destination_size_r),
		.pointer(destination_pointer),
		.counter(destination_counter),
		.expire(dst_expire)
	);

	// Control bits
	always_ff @(posedge core_clk) begin
		if (sys_rst || en_clr_w) begin
			enable_r <= 1'b0;
			transfer_go_r <= 1'b0;
			start_trigger_enable_r <= 1'b0;
			abort_trigger_enable_r <= 1'b0;
		end else begin
			if (en_set_w) enable_r <= 1'b1;
			if (abort_w) begin
				transfer_go_r <= 1'b0;
				start_trigger_enable_r <= 1'b0;
				abort_trigger_enable_r <= 1'b0;
			end else begin
				if (msg_end_w || sw_go_clr_w) transfer_go_r <= 1'b0;
				else if (sw_go_set_w || hw_start_w) transfer_go_r <= 1'b1;
				if (stop_opt_w) start_trigger_enable_r <= 1'b0;
				else if (wr_ctrl_w) start_trigger_enable_r <= avs_writedata[B_START_TRIGGER_ENABLE];
				if (wr_ctrl_w) abort_trigger_enable_r <= avs_writedata[B_ABORT_TRIGGER_ENABLE];
			end
		end
	end

	// Engine run lags control by one cycle
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			run_r <= 1'b0;
			state_r <= DMACH_IDLE;
		end else begin
			run_r <= transfer_go_r && enable_r;
			state_r <= state_nxt;
		end
	end

	// Buffer and pending status
	always_ff @(posedge core_clk) begin
		if (sys_rst || en_clr_w) begin
			transfer_buffer_r <= 8'h00;
			write_pending_r <= 1'b0;
		end else if (read_done_w) begin
			transfer_buffer_r <= rd_data;
			write_pending_r <= 1'b1;
		end else if (write_done_w || state_nxt == DMACH_IDLE) begin
			write_pending_r <= 1'b0;
		end
	end

	// Count flags: set wins over clear
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			source_count_flag_r <= 1'b0;
			destination_count_flag_r <= 1'b0;
		end else begin
			if (src_expire) source_count_flag_r <= 1'b1;
			else if (wr_flag_w && avs_writedata[B_SFLAG]) source_count_flag_r <= 1'b0;
			if (dst_expire) destination_count_flag_r <= 1'b1;
			else if (wr_flag_w && avs_writedata[B_DFLAG]) destination_count_flag_r <= 1'b0;
		end
	end

	// Configuration, writable only while disabled
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			source_address_mode_r <= MODE_HOLD;
			destination_address_mode_r <= MODE_HOLD;
			source_memory_region_r <= REGION_RAM;
			source_stop_r <= 1'b0;
			destination_stop_r <= 1'b0;
			source_start_address_r <= '0;
			destination_start_address_r <= '0;
			source_size_r <= CNT_W'(1);
			destination_size_r <= CNT_W'(1);
		end else begin
			if (wr_cfg_w) begin
				source_address_mode_r <= avs_writedata[F_SOURCE_ADDRESS_MODE+:2];
				destination_address_mode_r <= avs_writedata[F_DESTINATION_ADDRESS_MODE+:2];
				source_memory_region_r <= avs_writedata[F_SMR+:2];
				source_stop_r <= avs_writedata[B_SOURCE_STOP];
				destination_stop_r <= avs_writedata[B_DESTINATION_STOP];
			end
			if (wr_ssa_w && !enable_r) source_start_address_r <= avs_writedata[ADDR_W-1:0];
			if (wr_dsa_w && !enable_r) destination_start_address_r <= avs_writedata[ADDR_W-1:0];
			if (wr_ssz_w && !enable_r && avs_writedata[CNT_W-1:0] != '0) source_size_r <= avs_writedata[CNT_W-1:0];
			if (wr_dsz_w && !enable_r && avs_writedata[CNT_W-1:0] != '0)
				destination_size_r <= avs_writedata[CNT_W-1:0];
		end
	end

	// Read mux
	wire [31:0] ctrl_rd_w = {27'h0, write_pending_r, abort_trigger_enable_r, start_trigger_enable_r,
		transfer_go_r, enable_r};
	wire [31:0] cfg_rd_w = {24'h0, destination_stop_r, source_stop_r, source_memory_region_r,
		destination_address_mode_r, source_address_mode_r};
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = RD_UNMAPPED;
		unique case (avs_address)
			OFF_CTRL: rd_mux = ctrl_rd_w;
			OFF_CFG: rd_mux = cfg_rd_w;
			OFF_SSA: rd_mux = 32'(source_start_address_r);
			OFF_DSA: rd_mux = 32'(destination_start_address_r);
			OFF_SSZ: rd_mux = 32'(source_size_r);
			OFF_DSZ: rd_mux = 32'(destination_size_r);
			OFF_SPTR: rd_mux = 32'(source_pointer);
			OFF_DPTR: rd_mux = 32'(destination_pointer);
			OFF_SCNT: rd_mux = 32'(source_counter);
			OFF_DCNT: rd_mux = 32'(destination_counter);
			OFF_BUF: rd_mux = {24'h0, transfer_buffer_r};
			OFF_FLAG: rd_mux = {30'h0, destination_count_flag_r, source_count_flag_r};
			default: rd_mux = RD_UNMAPPED;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			ack_r <= 1'b0;
			waitreq_r <= 1'b1;
			rdata_r <= 32'h00000000;
		end else begin
			ack_r <= bus_req_w;
			waitreq_r <= !bus_req_w;
			rdata_r <= rd_mux;
		end
	end
	// Separate flop so the pin leaves the block without an inverter
	assign avs_waitrequest = waitreq_r;
	assign avs_readdata = rdata_r;

	// Bus requests, registered
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			rd_req_r <= '0;
			wr_req_r <= '0;
		end else begin
			rd_req_r.req <= (state_nxt == DMACH_READ);
			rd_req_r.region <= source_memory_region_r;
			rd_req_r.addr <= source_pointer;
			wr_req_r.req <= (state_nxt == DMACH_WRITE);
			wr_req_r.addr <= destination_pointer;
			wr_req_r.data <= (state_nxt == DMACH_WRITE && read_done_w) ? rd_data : transfer_buffer_r;
		end
	end
	assign rd_req = rd_req_r;
	assign wr_req = wr_req_r;
endmodule : dmach_top

// ### tb/dmach_sva.sv
// Port checker for the DMA channel: register bus handshake and memory bus transactions.
// Assumes it is bound to dmach_top and sees only its ports.
`timescale 1ns/100ps
module dmach_sva (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic [dmach_pkg::BUS_AW-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic avs_waitrequest,
	input wire dmach_pkg::dmach_rd_req_t rd_req,
	input wire logic rd_grant,
	input wire logic [7:0] rd_data,
	input wire dmach_pkg::dmach_wr_req_t wr_req,
	input wire logic wr_grant
);
	import dmach_pkg::*;
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	wire logic req_any = avs_read | avs_write;
	// Control write that drops transfer_go and start_trigger_enable
	wire logic stop_wr = avs_write && !avs_waitrequest && avs_address == OFF_CTRL && !avs_writedata[B_GO]
		&& !avs_writedata[B_START_TRIGGER_ENABLE];
	property p_ack; $rose(req_any) |=> !avs_waitrequest; endproperty
	property p_idle; !req_any |=> avs_waitrequest; endproperty
	property p_rst; disable iff (1'b0) sys_rst |=> avs_waitrequest && !rd_req.req && !wr_req.req; endproperty
	property p_onetx; !(rd_req.req && wr_req.req); endproperty
	property p_rdhold; rd_req.req && !rd_grant ##1 rd_req.req |-> $stable(rd_req.addr) && $stable(rd_req.region);
	endproperty
	property p_wrhold; wr_req.req && !wr_grant ##1 wr_req.req |-> $stable(wr_req.addr) && $stable(wr_req.data);
	endproperty
	property p_wrdat;
		logic [7:0] d;
		(rd_req.req && rd_grant, d = rd_data) ##[1:3] wr_req.req |-> wr_req.data == d;
	endproperty
	property p_gap; wr_req.req && wr_grant |=> !rd_req.req; endproperty
	property p_stop; stop_wr |-> ##[1:4] (!rd_req.req && !wr_req.req) [*2]; endproperty
	a_ack: assert property (p_ack) else $error("waitrequest not low one cycle after request");
	a_idle: assert property (p_idle) else $error("waitrequest low without request");
	a_rst: assert property (p_rst) else $error("outputs not idle after reset");
	a_onetx: assert property (p_onetx) else $error("read and write requested together");
	a_rdhold: assert property (p_rdhold) else $error("read request changed before grant");
	a_wrhold: assert property (p_wrhold) else $error("write request changed before grant");
	a_wrdat: assert property (p_wrdat) else $error("written byte differs from byte read");
	a_gap: assert property (p_gap) else $error("read requested right after write grant");
	a_stop: assert property (p_stop) else $error("requests not dropped after stop");
	c_wr: cover property (wr_req.req && wr_grant);
	c_stop: cover property (stop_wr && rd_req.req);
	c_back: cover property (wr_req.req && wr_grant ##2 rd_req.req);
endmodule : dmach_sva

// ### tb/dmach_mem.sv
// Memory and arbiter partner: grants reads and writes, returns data derived from address and space.
// Assumes requests hold until granted; stall withholds every grant.
`timescale 1ns/100ps
module dmach_mem (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic stall,
	input wire dmach_pkg::dmach_rd_req_t rd_req,
	input wire dmach_pkg::dmach_wr_req_t wr_req,
	output logic rd_grant,
	output logic [7:0] rd_data,
	output logic wr_grant
);
	import dmach_pkg::*;
	wire logic rd_go = rd_req.req && !rd_grant && !stall;
	// Data depends on the space, so a wrong region shows; idle data keeps moving
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			rd_grant <= 1'b0;
			wr_grant <= 1'b0;
			rd_data <= 8'hA5;
		end else begin
			rd_grant <= rd_go;
			wr_grant <= wr_req.req && !wr_grant && !stall;
			rd_data <= rd_go ? (rd_req.addr[7:0] ^ {rd_req.region, 6'h15}) : ~rd_data + 8'h3B;
		end
	end
endmodule : dmach_mem

// ### tb/dmach_tb.sv
// Self-checking bench for the DMA channel with a reference model of pointers and counters.
// Assumes dmach_top, dmach_mem and dmach_sva are compiled first.
`timescale 1ns/100ps
module dmach_tb;
	import dmach_pkg::*;
	logic core_clk = 1'b0, sys_rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
	logic [BUS_AW-1:0] avs_address = 6'h00;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, seed = 32'h00000048, rn;
	logic avs_waitrequest, start_request = 1'b0, abort_request = 1'b0, rd_grant, wr_grant;
	logic stall = 1'b0, hold = 1'b0, noise = 1'b0, sf = 1'b0, df = 1'b0;
	logic [7:0] rd_data, lb = 8'h00;
	dmach_rd_req_t rd_req;
	dmach_wr_req_t wr_req;
	logic [21:0] ssa, dsa, sp, dp;
	logic [11:0] ssz, dsz, sc, dc;
	logic [1:0] sm, dm, rg;
	int ntx = 0, error_cnt = 0, n_tests = 0;
	dmach_top i_dmach_top (.core_clk(core_clk), .sys_rst(sys_rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .start_request(start_request),
		.abort_request(abort_request), .rd_req(rd_req), .rd_grant(rd_grant), .rd_data(rd_data),
		.wr_req(wr_req), .wr_grant(wr_grant));
	dmach_mem i_dmach_mem (.core_clk(core_clk), .sys_rst(sys_rst), .stall(stall), .rd_req(rd_req),
		.wr_req(wr_req), .rd_grant(rd_grant), .rd_data(rd_data), .wr_grant(wr_grant));
	initial begin
		forever #10 core_clk = ~core_clk;
	end
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs
	function automatic logic [21:0] stp(input logic [21:0] p, input logic [1:0] m);
		return (m == MODE_INC) ? p + 22'h1 : (m == MODE_DEC) ? p - 22'h1 : p;
	endfunction : stp
	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
		n_tests++;
		if (s !== e) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask : cmp
	task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge core_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do begin
			@(posedge core_clk);
		end while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus
	task automatic chk(input string nm, input logic [5:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		cmp(nm, e, q);
	endtask : chk
	task automatic setup(input logic [11:0] s1, input logic [11:0] d1, input logic [7:0] c);
		logic [31:0] q;
		bus(1'b1, OFF_CTRL, 32'h0, q);
		ssa = 22'(xs());
		dsa = 22'(xs());
		{ssz, dsz, rg, dm, sm} = {s1, d1, c[5:0]};
		bus(1'b1, OFF_CFG, 32'(c), q);
		bus(1'b1, OFF_SSA, 32'(ssa), q);
		bus(1'b1, OFF_DSA, 32'(dsa), q);
		bus(1'b1, OFF_SSZ, 32'(ssz), q);
		bus(1'b1, OFF_DSZ, 32'(dsz), q);
		bus(1'b1, OFF_CTRL, 32'h1, q);
		{sp, dp, sc, dc} = {ssa, dsa, ssz, dsz};
		chk("sptr_load", OFF_SPTR, 32'(ssa));
		chk("scnt_load", OFF_SCNT, 32'(ssz));
		chk("dptr_load", OFF_DPTR, 32'(dsa));
		chk("dcnt_load", OFF_DCNT, 32'(dsz));
		ntx = 0;
	endtask : setup
	task automatic fin(input int n);
		logic [31:0] q;
		// Only the watchdog ends a message that never completes
		do begin
			bus(1'b0, OFF_CTRL, 32'h0, q);
		end while (q[B_GO] !== 1'b0);
		cmp("transactions", 32'(n), 32'(ntx));
		chk("scnt", OFF_SCNT, 32'(sc));
		chk("dcnt", OFF_DCNT, 32'(dc));
		chk("sptr", OFF_SPTR, 32'(sp));
		chk("dptr", OFF_DPTR, 32'(dp));
		chk("buf", OFF_BUF, 32'(lb));
		chk("flags", OFF_FLAG, 32'({df, sf}));
		bus(1'b1, OFF_FLAG, 32'h3, q);
		{sf, df} = 2'b00;
	endtask : fin
	task automatic msg();
		logic [31:0] q;
		int n;
		n = (sc < dc) ? sc : dc;
		ntx = 0;
		hold <= 1'b1;
		bus(1'b1, OFF_CTRL, 32'h3, q);
		bus(1'b1, OFF_CTRL, 32'h3, q);
		hold <= 1'b0;
		fin(n);
	endtask : msg
	task automatic conclude();
		$display("Comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : conclude
	// Random stalls; trigger noise while both trigger enables are off
	always @(posedge core_clk) begin
		rn = xs();
		stall <= hold | (rn[1:0] == 2'b00);
		if (noise) begin
			start_request <= rn[5];
			abort_request <= rn[9];
		end
	end
	// Reference model steps on every completed destination write
	always @(posedge core_clk) begin
		if (sys_rst === 1'b0 && wr_req.req === 1'b1 && wr_grant === 1'b1) begin
			cmp("wr_addr", 32'(dp), 32'(wr_req.addr));
			cmp("wr_data", 32'(sp[7:0] ^ {rg, 6'h15}), 32'(wr_req.data));
			lb = sp[7:0] ^ {rg, 6'h15};
			ntx++;
			{sc, sp, sf} = (sc == 12'h1) ? {ssz, ssa, 1'b1} : {sc - 12'h1, stp(sp, sm), sf};
			{dc, dp, df} = (dc == 12'h1) ? {dsz, dsa, 1'b1} : {dc - 12'h1, stp(dp, dm), df};
		end
	end
	initial begin
		repeat (50000) @(posedge core_clk);
		error_cnt++;
		$display("MISMATCH watchdog expected end seen hang");
		conclude();
	end
	initial begin
		logic [31:0] q;
		repeat (4) @(posedge core_clk);
		sys_rst <= 1'b0;
		chk("ctrl_rst", OFF_CTRL, 32'h0);
		chk("unmapped", 6'h30, RD_UNMAPPED);
		noise <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			setup((i == 0) ? 12'h3 : (i == 1) ? 12'h1 : 12'(xs() % 5 + 1),
				(i == 0) ? 12'h5 : (i == 1) ? 12'h1 : 12'(xs() % 5 + 1),
				8'({2'(i % 3), 2'((i + 1) % 3), 2'((i + 3) % 4)}));
			repeat (3) msg();
		end
		noise <= 1'b0;
		setup(12'h2, 12'h4, 8'h45);
		start_request <= 1'b0;
		abort_request <= 1'b0;
		hold <= 1'b1;
		bus(1'b1, OFF_CTRL, 32'h5, q);
		start_request <= 1'b1;
		repeat (8) @(posedge core_clk);
		chk("ctrl_hw", OFF_CTRL, 32'h7);
		hold <= 1'b0;
		fin(2);
		chk("ctrl_sstop", OFF_CTRL, 32'h1);
		repeat (30) @(posedge core_clk);
		// Both transactions of the stopped message, and nothing since
		cmp("no_restart", 32'h2, 32'(ntx));
		start_request <= 1'b0;
		setup(12'h3, 12'h3, 8'h19);
		hold <= 1'b1;
		// Abort lands while a stalled read is pending
		bus(1'b1, OFF_CTRL, 32'hF, q);
		abort_request <= 1'b1;
		repeat (10) @(posedge core_clk);
		chk("ctrl_abort", OFF_CTRL, 32'h1);
		hold <= 1'b0;
		repeat (10) @(posedge core_clk);
		bus(1'b1, OFF_CTRL, 32'h3, q);
		fin(3);
		abort_request <= 1'b0;
		// Soft stop right after start; the resumed message must pick up unchanged state
		bus(1'b1, OFF_CTRL, 32'h3, q);
		bus(1'b1, OFF_CTRL, 32'h1, q);
		repeat (10) @(posedge core_clk);
		chk("ctrl_soft", OFF_CTRL, 32'h1);
		msg();
		setup(12'h4, 12'h4, 8'h26);
		hold <= 1'b1;
		bus(1'b1, OFF_CTRL, 32'h3, q);
		bus(1'b1, OFF_CTRL, 32'h0, q);
		chk("ctrl_hard", OFF_CTRL, 32'h0);
		bus(1'b1, OFF_CTRL, 32'h3, q);
		chk("ctrl_nogo", OFF_CTRL, 32'h1);
		hold <= 1'b0;
		repeat (20) @(posedge core_clk);
		cmp("no_move", 32'h0, 32'(ntx));
		conclude();
	end
endmodule : dmach_tb
bind dmach_top dmach_sva i_dmach_sva (.core_clk(core_clk), .sys_rst(sys_rst), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
	.avs_waitrequest(avs_waitrequest), .rd_req(rd_req), .rd_grant(rd_grant), .rd_data(rd_data),
	.wr_req(wr_req), .wr_grant(wr_grant));
